// ===== logic/grl_cfg.svh
// Constants for the bus message handler: field positions, codes, timing.
// Assumes inclusion by the package, the handler module and the test bench.
`ifndef GRL_CFG_SVH
`define GRL_CFG_SVH
// Register byte addresses
`define GRL_ADDR_CTRL 12'h000
`define GRL_ADDR_MASK 12'h004
`define GRL_ADDR_STAT 12'h008
`define GRL_ADDR_EVT 12'h00C
// Trigger response codes
`define GRL_TRIG_IGNORE 2'h0
`define GRL_TRIG_IMMED 2'h1
`define GRL_TRIG_DELAY 2'h2
// Status byte positions, condition width, mask reset value
`define GRL_BIT_RQS 6
`define GRL_COND_W 6
`define GRL_MASK_RST 8'h00
// Settling delay, in microseconds
`define GRL_SETTLE_US 100
`define GRL_CLK_MHZ 125
`define GRL_SETTLE_CYC (`GRL_SETTLE_US * `GRL_CLK_MHZ)
`endif

// ===== logic/grl_pkg.sv
// Types shared by the bus message handler.
// Assumes grl_cfg.svh is on the include path.
`include "grl_cfg.svh"
package grl_pkg;
	// Bus commands decoded by the interface front end, one-cycle each
	typedef struct packed {
		logic sdc;
		logic dcl;
		logic get;
		logic gtl;
		logic llo;
		logic tct;
		logic spoll;
		logic cls;
	} grl_cmd_t;
	// Addressing and line state, levels
	typedef struct packed {
		logic ren;
		logic lad;
		logic tad;
	} grl_bus_t;
	typedef enum logic [2:0] {
		GRL_LOCAL = 3'h1,
		GRL_REMOTE = 3'h2,
		GRL_LOCK_REM = 3'h4
	} grl_rl_t;
	typedef enum logic [2:0] {
		GRL_T_IDLE = 3'h1,
		GRL_T_WAIT = 3'h2,
		GRL_T_FIRE = 3'h4
	} grl_trig_t;
endpackage : grl_pkg

// ===== logic/grl_handler.sv
// Device-side bus message handler: clear, trigger, remote/local, SRQ.
// Assumes decoded one-cycle bus command strobes, synchronous to core_clk_in.
//
// Functional notes
// - Device clear aborts pending or running bus transfers.
// - Selected clear needs listen addressing; universal clear always acts.
// - Trigger in remote and listen runs the programmed trigger response.
// - Trigger response: ignore, immediate measure, or delayed measure.
// - Default and power-up response is one delayed settled measurement.
// - Remote entered only on first listen addressing after REN true.
// - Local to remote changes no instrument setting.
// - Remote indicator on in remote, off in local.
// - Go-to-local while listening returns to local; lockout flag stays.
// - Lockout flag set means next remote is with lockout unless REN dropped.
// - Listen and talk indicators follow addressing in any mode.
// - Local lockout in remote disables the front-panel local key.
// - Lockout in local with REN gives remote lockout on next listen.
// - Lockout ends only on go-to-local, REN false, or reset.
// - REN false gives local, clears lockout, remote indicator off.
// - Pass control ignored; never becomes controller.
// - SRQ may be asserted in local and remote.
// - SRQ indicator on while SRQ asserted.
// - Serial poll or clear-status drops the service request.
// - Six conditions raise a request only when their mask bit is set.
// - Data ready on triggered result; cal/zero complete on cycle end.
// - Entry error on out-of-range bus value.
// - Measurement error on invalid sensor input.
// - Mask clears to zero at reset.
// - Enabled condition sets its status bit, bit 6, then SRQ.
`timescale 1ns/1ns
`default_nettype none
`include "grl_cfg.svh"
module grl_handler import grl_pkg::*; #(
	parameter int SETTLE_CYC = `GRL_SETTLE_CYC
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire grl_cmd_t cmd_in,
	input wire grl_bus_t bus_in,
	input wire logic [`GRL_COND_W-1:0] cond_in,
	input wire logic xfer_busy_in,
	input wire logic local_key_in,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic xfer_abort_out,
	output logic immediate_measure_cmd_out,
	output logic delayed_measure_cmd_out,
	output logic remote_indicator_out,
	output logic listen_indicator_out,
	output logic talk_indicator_out,
	output logic lockout_out,
	output logic srq_out,
	output logic srq_indicator_out,
	output logic ctrl_active_out
);
	localparam int CNT_W = $clog2(SETTLE_CYC + 1);
	initial begin
		if (SETTLE_CYC < 1)
			$error("SETTLE_CYC must be at least one cycle");
	end

	grl_rl_t rl_state;
	grl_trig_t trig_state;
	logic [1:0] trig_mode;
	logic [7:0] srq_mask;
	logic [`GRL_COND_W-1:0] cond_latch;
	logic [CNT_W-1:0] settle_cnt;
	logic lock_flag;
	logic lad_q;
	logic ren_q;
	logic rqs;
	logic clr_do;
	logic trig_do;
	logic ren_fall;
	logic lad_first;
	logic wr_en;
	logic rd_en;
	logic [`GRL_COND_W-1:0] next_cond;

	// Decoded strobes
	assign clr_do = cmd_in.dcl | (cmd_in.sdc & bus_in.lad);
	assign trig_do = cmd_in.get & bus_in.lad & (rl_state != GRL_LOCAL);
	assign ren_fall = ren_q & ~bus_in.ren;
	assign lad_first = bus_in.lad & ~lad_q;
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;

	// Edge history of REN and listen address
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			lad_q <= 1'b0;
			ren_q <= 1'b0;
		end else begin
			lad_q <= bus_in.lad;
			ren_q <= bus_in.ren;
		end
	end

	// Abort pulse; only bus transfer state is touched, never settings
	always_ff @(posedge core_clk_in) begin
		if (rst_in)
			xfer_abort_out <= 1'b0;
		else
			xfer_abort_out <= clr_do & xfer_busy_in;
	end

	// Remote/local state; settings live elsewhere and are untouched
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rl_state <= GRL_LOCAL;
		end else if (!bus_in.ren) begin
			rl_state <= GRL_LOCAL;
		end else begin
			case (rl_state)
				GRL_LOCAL: begin
					if (lad_first && (lock_flag || cmd_in.llo))
						rl_state <= GRL_LOCK_REM;
					else if (lad_first)
						rl_state <= GRL_REMOTE;
				end
				GRL_REMOTE: begin
					if (cmd_in.gtl && bus_in.lad)
						rl_state <= GRL_LOCAL;
					else if (local_key_in && !lock_flag)
						rl_state <= GRL_LOCAL;
					else if (cmd_in.llo)
						rl_state <= GRL_LOCK_REM;
				end
				GRL_LOCK_REM: begin
					if (cmd_in.gtl && bus_in.lad)
						rl_state <= GRL_LOCAL;
				end
				default: rl_state <= GRL_LOCAL;
			endcase
		end
	end

	// Lockout flag survives go-to-local; only REN or reset clears it
	always_ff @(posedge core_clk_in) begin
		if (rst_in)
			lock_flag <= 1'b0;
		else if (!bus_in.ren)
			lock_flag <= 1'b0;
		else if (cmd_in.llo)
			lock_flag <= 1'b1;
	end

	// Indicators; pass control is never decoded, so no controller role
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			remote_indicator_out <= 1'b0;
			listen_indicator_out <= 1'b0;
			talk_indicator_out <= 1'b0;
			lockout_out <= 1'b0;
			ctrl_active_out <= 1'b0;
		end else begin
			remote_indicator_out <= (rl_state != GRL_LOCAL);
			listen_indicator_out <= bus_in.lad;
			talk_indicator_out <= bus_in.tad;
			lockout_out <= (rl_state == GRL_LOCK_REM);
			ctrl_active_out <= 1'b0;
		end
	end

	// Trigger dispatcher with settling delay
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			trig_state <= GRL_T_IDLE;
			settle_cnt <= '0;
			immediate_measure_cmd_out <= 1'b0;
			delayed_measure_cmd_out <= 1'b0;
		end else begin
			immediate_measure_cmd_out <= 1'b0;
			delayed_measure_cmd_out <= 1'b0;
			case (trig_state)
				GRL_T_IDLE: begin
					if (trig_do && trig_mode == `GRL_TRIG_IMMED) begin
						immediate_measure_cmd_out <= 1'b1;
					end else if (trig_do && trig_mode == `GRL_TRIG_DELAY) begin
						trig_state <= GRL_T_WAIT;
						settle_cnt <= CNT_W'(SETTLE_CYC - 1);
					end
				end
				GRL_T_WAIT: begin
					if (clr_do)
						trig_state <= GRL_T_IDLE;
					else if (settle_cnt == '0)
						trig_state <= GRL_T_FIRE;
					else
						settle_cnt <= settle_cnt - 1'b1;
				end
				GRL_T_FIRE: begin
					delayed_measure_cmd_out <= 1'b1;
					trig_state <= GRL_T_IDLE;
				end
				default: trig_state <= GRL_T_IDLE;
			endcase
		end
	end

	// Software registers: trigger mode and mask
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			trig_mode <= `GRL_TRIG_DELAY;
			srq_mask <= `GRL_MASK_RST;
		end else if (wr_en) begin
			if (paddr == `GRL_ADDR_CTRL && pwdata[1:0] != 2'h3)
				trig_mode <= pwdata[1:0];
			if (paddr == `GRL_ADDR_MASK)
				srq_mask <= pwdata[7:0];
		end
	end

	// Condition latches; a new event wins over a same-cycle clear
	always_comb begin
		next_cond = cond_latch;
		if (cmd_in.cls || cmd_in.spoll)
			next_cond = '0;
		if (wr_en && paddr == `GRL_ADDR_EVT)
			next_cond = next_cond & ~pwdata[`GRL_COND_W-1:0];
		next_cond = next_cond | cond_in;
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in)
			cond_latch <= '0;
		else
			cond_latch <= next_cond;
	end

	// Request service: any latched and enabled condition
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rqs <= 1'b0;
			srq_out <= 1'b0;
			srq_indicator_out <= 1'b0;
		end else begin
			rqs <= |(next_cond & srq_mask[`GRL_COND_W-1:0]);
			srq_out <= rqs;
			srq_indicator_out <= rqs;
		end
	end

	// APB slave, zero wait states; unmapped reads return zero.
	// Read data is captured in the setup cycle and stands through the
	// access cycle, so pready can be a plain registered setup flag.
	// Map: CTRL holds the trigger mode, MASK the request mask, STAT the
	// remote/local state with indicator and lockout flag, EVT the latched
	// conditions with the request bit above them.
	// EVT is write-one-to-clear; a new condition in that cycle still wins.
	// Limitation: no error response, pslverr stays low for every access.
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			if (rd_en) begin
				case (paddr)
					`GRL_ADDR_CTRL: prdata <= {30'h0, trig_mode};
					`GRL_ADDR_MASK: prdata <= {24'h0, srq_mask};
					`GRL_ADDR_STAT: prdata <= {27'h0, lock_flag,
						remote_indicator_out, rl_state};
					`GRL_ADDR_EVT: prdata <= {24'h0, 1'b0, rqs,
						cond_latch};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Checks
	AST_LOCAL_NO_REN: assert property (@(posedge core_clk_in) disable iff
		(rst_in) !bus_in.ren |=> rl_state == GRL_LOCAL && !lock_flag)
		else $error("remote state held without REN");
	AST_REMOTE_NEEDS_LAD: assert property (@(posedge core_clk_in)
		disable iff (rst_in) $rose(rl_state != GRL_LOCAL) |->
		$past(lad_first))
		else $error("remote entered without first listen address");
	AST_RMT_IND: assert property (@(posedge core_clk_in) disable iff
		(rst_in) remote_indicator_out == $past(rl_state != GRL_LOCAL))
		else $error("remote indicator mismatch");
	AST_LOCK_STAYS: assert property (@(posedge core_clk_in) disable iff
		(rst_in) lock_flag && bus_in.ren |=> lock_flag)
		else $error("lockout flag cleared with REN true");
	AST_IMMED: assert property (@(posedge core_clk_in) disable iff (rst_in)
		trig_do && trig_mode == `GRL_TRIG_IMMED && trig_state == GRL_T_IDLE
		|=> immediate_measure_cmd_out)
		else $error("immediate trigger not issued");
	AST_IGNORE: assert property (@(posedge core_clk_in) disable iff (rst_in)
		trig_do && trig_mode == `GRL_TRIG_IGNORE && trig_state == GRL_T_IDLE
		|=> !immediate_measure_cmd_out ##1 trig_state == GRL_T_IDLE)
		else $error("ignored trigger acted on");
	AST_SRQ_MASKED: assert property (@(posedge core_clk_in) disable iff
		(rst_in) srq_mask == 8'h00 && $past(srq_mask) == 8'h00
		|=> ##1 !srq_out)
		else $error("SRQ raised with empty mask");
	AST_SRQ_IND: assert property (@(posedge core_clk_in) disable iff (rst_in)
		srq_out == srq_indicator_out)
		else $error("SRQ indicator differs from SRQ");
	AST_ABORT: assert property (@(posedge core_clk_in) disable iff (rst_in)
		cmd_in.dcl && xfer_busy_in |=> xfer_abort_out)
		else $error("device clear did not abort");
	AST_LATCH: assert property (@(posedge core_clk_in) disable iff (rst_in)
		cond_in[0] |=> cond_latch[0])
		else $error("condition not latched");

	// Indicator and role checks; indicators lag their lines by one edge
	// Listen indicator follows the listen address
	AST_LISTEN_IND: assert property (@(posedge core_clk_in) disable iff
		(rst_in) listen_indicator_out == $past(bus_in.lad))
		else $error("listen indicator mismatch");
	// Talk indicator follows the talk address
	AST_TALK_IND: assert property (@(posedge core_clk_in) disable iff
		(rst_in) talk_indicator_out == $past(bus_in.tad))
		else $error("talk indicator mismatch");
	// Controller role is never taken
	AST_NO_CTRL: assert property (@(posedge core_clk_in) disable iff
		(rst_in) !ctrl_active_out)
		else $error("controller role taken");
	// Lockout holds until go-to-local or REN false; key has no effect
	AST_LOCK_HOLDS: assert property (@(posedge core_clk_in) disable iff
		(rst_in) rl_state == GRL_LOCK_REM && bus_in.ren && !cmd_in.gtl
		|=> rl_state == GRL_LOCK_REM)
		else $error("lockout left without cause");
	// Selected clear while unaddressed must not abort
	AST_SDC_UNADDR: assert property (@(posedge core_clk_in) disable iff
		(rst_in) cmd_in.sdc && !cmd_in.dcl && !bus_in.lad
		|=> !xfer_abort_out)
		else $error("unaddressed selected clear acted");
	// End of settling always issues the delayed measurement
	AST_DELAY_FIRE: assert property (@(posedge core_clk_in) disable iff
		(rst_in) trig_state == GRL_T_FIRE |=> delayed_measure_cmd_out)
		else $error("delayed measurement not issued");
	// A clear during settling drops the pending trigger
	AST_CLR_DROP_TRIG: assert property (@(posedge core_clk_in) disable iff
		(rst_in) trig_state == GRL_T_WAIT && clr_do
		|=> trig_state == GRL_T_IDLE)
		else $error("pending trigger survived clear");
	// Poll or clear-status empties the latches when nothing new arrives
	AST_STATUS_CLEAR: assert property (@(posedge core_clk_in) disable iff
		(rst_in) (cmd_in.cls || cmd_in.spoll) && cond_in == '0
		|=> cond_latch == '0)
		else $error("conditions not cleared");
	// Mask is empty on the first edge after reset
	AST_MASK_RESET: assert property (@(posedge core_clk_in) disable iff
		(rst_in) $fell(rst_in) |-> srq_mask == `GRL_MASK_RST)
		else $error("mask not cleared by reset");
	// Zero wait states: access cycle always sees pready
	AST_APB_READY: assert property (@(posedge core_clk_in) disable iff
		(rst_in) psel && !penable |=> pready)
		else $error("pready missing in access cycle");
endmodule : grl_handler
`default_nettype wire

// ===== testbench/grl_ctl_model.sv
// Bus controller model: command strobes and bus line levels.
// Assumes callers enter its tasks just after a rising clk_in edge.
`timescale 1ns/1ns
`default_nettype none
module grl_ctl_model import grl_pkg::*; (
	input wire logic clk_in,
	output var grl_cmd_t cmd_out,
	output var grl_bus_t bus_out
);
	// Idle bus: no strobes, lines false
	initial begin
		cmd_out = '0;
		bus_out = '0;
	end
	// One-cycle command strobe, bit 7 sdc down to bit 0 cls
	task pulse(input int b);
		cmd_out <= grl_cmd_t'(8'h01 << b);
		@(posedge clk_in);
		cmd_out <= '0;
	endtask : pulse
	// Enable line settles a cycle before any addressing changes
	task set_bus(input logic r, input logic l, input logic t);
		bus_out.ren <= r;
		@(posedge clk_in);
		bus_out.lad <= l;
		bus_out.tad <= t;
		@(posedge clk_in);
	endtask : set_bus
endmodule : grl_ctl_model
`default_nettype wire

// ===== testbench/gpib_remote_local_trigger_srq_bench.sv
// Self-checking bench for the bus message handler.
// Assumes the handler answers APB with zero wait states.
`timescale 1ns/1ns
`default_nettype none
`include "grl_cfg.svh"
module gpib_remote_local_trigger_srq_bench import grl_pkg::*; ;
	logic clk, rst, busy, key, psel, pen, pwr;
	logic [11:0] pa;
	logic [31:0] pwd, q, prd;
	logic [5:0] cond;
	grl_cmd_t cmd;
	grl_bus_t bus;
	logic prdy, slv, abt, imm, dly, rem_ind, lis_ind, talk_ind;
	logic lko, srq, srqi, ctla;
	int failures = 0, comparisons = 0, cyc = 0, n_imm = 0, n_dly = 0, n_abt = 0;
	grl_ctl_model ctl_i(.clk_in(clk), .cmd_out(cmd), .bus_out(bus));
	grl_handler #(.SETTLE_CYC(4)) grl_handler_i(.core_clk_in(clk),
		.rst_in(rst), .cmd_in(cmd), .bus_in(bus), .cond_in(cond),
		.xfer_busy_in(busy), .local_key_in(key), .psel(psel),
		.penable(pen), .pwrite(pwr), .paddr(pa), .pwdata(pwd),
		.prdata(prd), .pready(prdy), .pslverr(slv), .xfer_abort_out(abt),
		.immediate_measure_cmd_out(imm), .delayed_measure_cmd_out(dly),
		.remote_indicator_out(rem_ind), .listen_indicator_out(lis_ind),
		.talk_indicator_out(talk_ind), .lockout_out(lko), .srq_out(srq),
		.srq_indicator_out(srqi), .ctrl_active_out(ctla));
	// 125 MHz clock
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	// Pulse counters and hang guard, far above the expected run length
	always @(posedge clk) begin
		cyc++;
		n_imm += imm;
		n_dly += dly;
		n_abt += abt;
		if (cyc == 5000) begin
			failures++;
			close_out;
		end
	end
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// One APB transfer; request held until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1;
		pen <= 0;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1;
		n = 0;
		do @(posedge clk); while (prdy !== 1'b1 && ++n < 50);
		if (n >= 50)
			failures++;
		q = prd;
		psel <= 0;
		pen <= 0;
		// One idle edge so a following call never reassigns in this step
		@(posedge clk);
	endtask : apb
	task rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(0, a, 32'h0);
		chk(nm, q, e);
		chk("slverr", slv, 0);
	endtask : rdchk
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task t_remote;
		rdchk(`GRL_ADDR_CTRL, 32'h2, "trig mode");
		rdchk(`GRL_ADDR_MASK, 32'h0, "mask");
		rdchk(12'h010, 32'h0, "unmapped");
		ctl_i.set_bus(0, 1, 0);
		tick(2);
		chk("remote no ren", rem_ind, 0);
		chk("listen", lis_ind, 1);
		ctl_i.set_bus(1, 0, 1);
		tick(2);
		chk("talk", talk_ind, 1);
		ctl_i.set_bus(1, 1, 0);
		tick(2);
		chk("remote", rem_ind, 1);
		rdchk(`GRL_ADDR_STAT, 32'h0A, "status");
		rdchk(`GRL_ADDR_CTRL, 32'h2, "settings kept");
		$display("remote test done");
	endtask : t_remote
	task t_trig;
		for (int m = 0; m < 3; m++) begin
			apb(1, `GRL_ADDR_CTRL, m);
			n_imm = 0;
			n_dly = 0;
			ctl_i.pulse(5);
			tick(12);
			chk("immediate", n_imm, m == 1);
			chk("delayed", n_dly, m == 2);
		end
		apb(1, `GRL_ADDR_CTRL, 32'h3);
		rdchk(`GRL_ADDR_CTRL, 32'h2, "mode 3 refused");
		$display("trigger test done");
	endtask : t_trig
	task t_clear;
		busy <= 1;
		ctl_i.set_bus(1, 0, 0);
		n_abt = 0;
		ctl_i.pulse(7);
		tick(4);
		chk("sdc unaddressed", n_abt, 0);
		ctl_i.pulse(6);
		tick(4);
		chk("dcl", n_abt, 1);
		ctl_i.set_bus(1, 1, 0);
		ctl_i.pulse(7);
		tick(4);
		chk("sdc", n_abt, 2);
		busy <= 0;
		$display("clear test done");
	endtask : t_clear
	task t_lock;
		key <= 1;
		tick(1);
		key <= 0;
		tick(2);
		chk("key local", rem_ind, 0);
		ctl_i.set_bus(1, 0, 0);
		ctl_i.set_bus(1, 1, 0);
		tick(2);
		chk("remote again", rem_ind, 1);
		ctl_i.pulse(3);
		tick(2);
		chk("lockout", lko, 1);
		key <= 1;
		tick(1);
		key <= 0;
		tick(2);
		chk("key locked", rem_ind, 1);
		ctl_i.pulse(4);
		tick(2);
		chk("gtl", rem_ind, 0);
		rdchk(`GRL_ADDR_STAT, 32'h11, "status gtl");
		ctl_i.set_bus(1, 0, 0);
		ctl_i.set_bus(1, 1, 0);
		tick(2);
		rdchk(`GRL_ADDR_STAT, 32'h1C, "status relock");
		ctl_i.set_bus(0, 1, 0);
		tick(2);
		chk("ren off", rem_ind, 0);
		chk("ren off lock", lko, 0);
		rdchk(`GRL_ADDR_STAT, 32'h01, "status ren off");
		ctl_i.set_bus(1, 0, 0);
		ctl_i.pulse(3);
		ctl_i.set_bus(1, 1, 0);
		tick(2);
		chk("llo in local", lko, 1);
		ctl_i.pulse(2);
		tick(2);
		chk("ctrl role", ctla, 0);
		ctl_i.set_bus(0, 0, 0);
		$display("lockout test done");
	endtask : t_lock
	task t_srq;
		apb(1, `GRL_ADDR_MASK, 32'h1);
		cond <= 6'h02;
		tick(1);
		cond <= 0;
		tick(4);
		chk("masked", srq, 0);
		for (int i = 0; i < 6; i++) begin
			apb(1, `GRL_ADDR_MASK, 32'h1 << i);
			cond <= 6'h01 << i;
			tick(1);
			cond <= 0;
			tick(4);
			chk("srq", srq, 1);
			chk("srq ind", srqi, 1);
			rdchk(`GRL_ADDR_EVT, (32'h1 << i) | 32'h40 | (i == 0 ? 2 : 0),
				"events");
			ctl_i.pulse(i[0] ? 0 : 1);
			tick(3);
			chk("srq drop", srq, 0);
		end
		$display("service request test done");
	endtask : t_srq
	task close_out;
		$display("counts: %0d comparisons, %0d failures", comparisons,
			failures);
		if (failures == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out
	// Main sequence
	initial begin
		rst <= 1;
		busy <= 0;
		key <= 0;
		psel <= 0;
		pen <= 0;
		pwr <= 0;
		pa <= '0;
		pwd <= '0;
		cond <= '0;
		tick(12);
		rst <= 0;
		tick(1);
		chk("srq reset", srq, 0);
		t_remote;
		t_trig;
		t_clear;
		t_lock;
		t_srq;
		close_out;
	end
endmodule : gpib_remote_local_trigger_srq_bench
`default_nettype wire
